// *** hw/exec_params.svh ***
// Purpose: Offsets, field positions and codes for the byte execution datapath.
// Assumes: 16-bit instruction word, 8-bit data, 12-bit data address.
// Notes:   Included by bare name.
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH

`define OPC_MSB           15
`define OPC_LSB           10
`define OPC_SUB_BORROW    6'h16
`define OPC_NIBBLE_SWAP   6'h0e
`define DEST_BIT          9
`define BANK_BIT          8
`define FILE_MSB          7
`define ACCESS_LIMIT      8'h5f
`define ACCESS_LOW_BANK   4'h0
`define ACCESS_HIGH_BANK  4'hf
`define ST_C              0
`define ST_DIGIT_CARRY    1
`define ST_Z              2
`define ST_OVERFLOW       3
`define ST_N              4
`define STATUS_RESET      5'h00
`define W_RESET           8'h00

`endif

// *** hw/exec_pkg.sv ***
// Purpose: Types shared by the execution datapath files.
// Assumes: Four phases per instruction cycle.
// Notes:   Numbers live in exec_params.svh.
package exec_pkg;

   typedef enum logic [1:0] {
      PH_Q1 = 2'b00,
      PH_Q2 = 2'b01,
      PH_Q3 = 2'b10,
      PH_Q4 = 2'b11
   } phase_e;

   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_SUB  = 2'b01,
      OP_SWAP = 2'b10
   } op_e;

   typedef logic [11:0] addr_t;
   typedef logic [4:0]  status_t;
   typedef logic [7:0]  byte_t;

   typedef struct packed {
      phase_e  phase;
      op_e     op;
      logic    dest_f;
      addr_t   addr;
      logic    mem_re;
      logic    mem_we;
      byte_t   wdata;
      byte_t   operand;
      byte_t   w;
      status_t status;
      logic    done;
   } state_s;

endpackage

// *** hw/alu_if.sv ***
// Purpose: Carries operands and results between the sequencer and the ALU.
// Assumes: Combinational ALU.
// Notes:   Flags are indexed by the status bit positions.
interface alu_if;
   logic [7:0] operand;
   logic [7:0] w_val;
   logic       carry_in;
   logic       is_sub;
   logic [7:0] result;
   logic [4:0] flags;

   modport core (output operand, output w_val, output carry_in, output is_sub,
                 input result, input flags);
   modport alu  (input operand, input w_val, input carry_in, input is_sub,
                 output result, output flags);
endinterface

// *** hw/nibble_alu.sv ***
// Purpose: Borrow subtract and nibble swap arithmetic.
// Assumes: Carry in is the stored carry flag.
// Notes:   Purely combinational.
`include "exec_params.svh"
module nibble_alu
(
   // Operand and result bundle
   alu_if.alu bus
);
   logic [8:0] full_sum;
   logic [4:0] low_sum;
   logic [7:0] diff;

   // Two's complement: f + ~w + c equals f - w - !c.
   assign full_sum = {1'b0, bus.operand} + {1'b0, ~bus.w_val} + {8'h00, bus.carry_in};
   assign low_sum  = {1'b0, bus.operand[3:0]} + {1'b0, ~bus.w_val[3:0]}
                     + {4'h0, bus.carry_in};
   assign diff     = full_sum[7:0];

   assign bus.result = bus.is_sub ? diff
                                  : {bus.operand[3:0], bus.operand[7:4]};

   // Carry and digit carry are set when no borrow occurs.
   assign bus.flags[`ST_C]  = full_sum[8];
   assign bus.flags[`ST_DIGIT_CARRY] = low_sum[4];
   assign bus.flags[`ST_Z]  = (diff == 8'h00);
   assign bus.flags[`ST_N]  = diff[7];
   assign bus.flags[`ST_OVERFLOW] = (bus.operand[7] ^ bus.w_val[7])
                                    & (diff[7] ^ bus.operand[7]);
endmodule

// *** hw/borrow_subtract_nibble_swap_exec.sv ***
// Purpose: Four-phase execution of the borrow subtract and nibble swap instructions.
// Assumes: Data memory answers a read in the same cycle; instruction from core logic.
// Notes:   One clock edge per phase; the phase counter runs freely.
`include "exec_params.svh"

// Overview of operation
// - Subtract W and inverted carry from f.
// - Swap nibbles of f, flags unchanged.
// - Destination bit selects W or file.
// - Bank bit selects access bank or bank register.
// - Extended set uses indexed offset below 96.
// - Decode, read, process, write over four phases.
module borrow_subtract_nibble_swap_exec
#(
   parameter int BANK_W = 4
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Instruction
   input  wire logic             instr_valid,
   input  wire logic [15:0]      instr,
   output exec_pkg::phase_e      phase_q,
   output logic                  done_q,
   // Core context
   input  wire logic [BANK_W-1:0] bank_select_reg,
   input  wire logic             ext_set_en,
   input  wire exec_pkg::addr_t  index_base,
   // Data memory
   output exec_pkg::addr_t       mem_addr_q,
   output logic                  mem_re_q,
   input  wire exec_pkg::byte_t  mem_rdata,
   output logic                  mem_we_q,
   output exec_pkg::byte_t       mem_wdata_q,
   // Working register and status
   input  wire logic             preset_valid,
   input  wire exec_pkg::byte_t  preset_w,
   input  wire exec_pkg::status_t preset_status,
   output exec_pkg::byte_t       w_q,
   output exec_pkg::status_t     status_q
);
   import exec_pkg::*;

   if (BANK_W != 4) begin : g_check
      $error("BANK_W must be 4 for a 12-bit data address");
   end

   state_s s_q;
   state_s s_d;
   op_e    dec_op;
   addr_t  eff_addr;
   byte_t  file_f;
   logic   taken;

   alu_if alu_bus ();

   nibble_alu u_alu
   (
      .bus (alu_bus)
   );

   assign alu_bus.operand  = s_q.operand;
   assign alu_bus.w_val    = s_q.w;
   assign alu_bus.carry_in = s_q.status[`ST_C];
   assign alu_bus.is_sub   = (s_q.op == OP_SUB);

   assign file_f = instr[`FILE_MSB:0];
   assign taken  = (s_q.phase == PH_Q1) && instr_valid && (dec_op != OP_NONE);

   // Decodes the opcode and forms the effective data address.
   always_comb
   begin
      dec_op = OP_NONE;
      if (instr[`OPC_MSB:`OPC_LSB] == `OPC_SUB_BORROW)
      begin
         dec_op = OP_SUB;
      end
      else if (instr[`OPC_MSB:`OPC_LSB] == `OPC_NIBBLE_SWAP)
      begin
         dec_op = OP_SWAP;
      end
      if (instr[`BANK_BIT])
      begin
         eff_addr = {bank_select_reg, file_f};
      end
      else if (ext_set_en && (file_f <= `ACCESS_LIMIT))
      begin
         eff_addr = addr_t'(index_base + {4'h0, file_f});
      end
      else if (file_f <= `ACCESS_LIMIT)
      begin
         eff_addr = {`ACCESS_LOW_BANK, file_f};
      end
      else
      begin
         eff_addr = {`ACCESS_HIGH_BANK, file_f};
      end
   end

   // Sequences one instruction through the four phases.
   always_comb
   begin
      s_d        = s_q;
      s_d.phase  = phase_e'(2'(s_q.phase + 2'h1));
      s_d.mem_re = 1'b0;
      s_d.mem_we = 1'b0;
      s_d.done   = 1'b0;
      case (s_q.phase)
         PH_Q1:
         begin
            s_d.op = OP_NONE;
            if (taken)
            begin
               s_d.op     = dec_op;
               s_d.dest_f = instr[`DEST_BIT];
               s_d.addr   = eff_addr;
               s_d.mem_re = 1'b1;
            end
            else if (preset_valid)
            begin
               s_d.w      = preset_w;
               s_d.status = preset_status;
            end
         end
         PH_Q2:
         begin
            s_d.operand = mem_rdata;
         end
         PH_Q3:
         begin
            if (s_q.op != OP_NONE)
            begin
               s_d.done = 1'b1;
               if (s_q.dest_f)
               begin
                  s_d.mem_we = 1'b1;
                  s_d.wdata  = alu_bus.result;
               end
               else
               begin
                  s_d.w = alu_bus.result;
               end
               if (s_q.op == OP_SUB)
               begin
                  s_d.status = alu_bus.flags;
               end
            end
         end
         PH_Q4:
         begin
            s_d.op = s_q.op;
         end
         default:
         begin
            s_d.op = OP_NONE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_q        <= '0;
         s_q.w      <= `W_RESET;
         s_q.status <= `STATUS_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign phase_q     = s_q.phase;
   assign done_q      = s_q.done;
   assign mem_addr_q  = s_q.addr;
   assign mem_re_q    = s_q.mem_re;
   assign mem_we_q    = s_q.mem_we;
   assign mem_wdata_q = s_q.wdata;
   assign w_q         = s_q.w;
   assign status_q    = s_q.status;

   // Checks on the datapath behaviour.
   a_sub_result: assert property (@(posedge clk) disable iff (rst)
      (s_q.phase == PH_Q3 && s_q.op == OP_SUB && s_q.dest_f) |=> (mem_we_q &&
      mem_wdata_q == 8'($past(s_q.operand) - $past(s_q.w)
      - {7'h00, ~$past(s_q.status[`ST_C])})))
      else $error("borrow subtract result wrong");

   a_swap_nibbles: assert property (@(posedge clk) disable iff (rst)
      (s_q.phase == PH_Q3 && s_q.op == OP_SWAP && s_q.dest_f) |=>
      (mem_wdata_q == {$past(s_q.operand[3:0]), $past(s_q.operand[7:4])}))
      else $error("nibble swap result wrong");

   a_swap_flags: assert property (@(posedge clk) disable iff (rst)
      (s_q.phase == PH_Q3 && s_q.op == OP_SWAP) |=> $stable(status_q))
      else $error("nibble swap changed flags");

   a_dest_w: assert property (@(posedge clk) disable iff (rst)
      (s_q.phase == PH_Q3 && s_q.op != OP_NONE && !s_q.dest_f) |=>
      (!mem_we_q && done_q && w_q == $past(alu_bus.result)))
      else $error("working register destination wrong");

   a_bank_reg: assert property (@(posedge clk) disable iff (rst)
      (taken && instr[`BANK_BIT]) |=>
      (mem_addr_q == {$past(bank_select_reg), $past(file_f)}))
      else $error("bank register address wrong");

   a_access_high: assert property (@(posedge clk) disable iff (rst)
      (taken && !instr[`BANK_BIT] && file_f > `ACCESS_LIMIT) |=>
      (mem_addr_q == {`ACCESS_HIGH_BANK, $past(file_f)}))
      else $error("access bank address wrong");

   a_indexed_mode: assert property (@(posedge clk) disable iff (rst)
      (taken && !instr[`BANK_BIT] && ext_set_en && file_f <= `ACCESS_LIMIT) |=>
      (mem_addr_q == addr_t'($past(index_base) + {4'h0, $past(file_f)})))
      else $error("indexed offset address wrong");

   a_phase_walk: assert property (@(posedge clk) disable iff (rst)
      taken |=> (phase_q == PH_Q2 && mem_re_q) ##1 (phase_q == PH_Q3 && !mem_re_q)
      ##1 (phase_q == PH_Q4 && done_q) ##1 (phase_q == PH_Q1 && !done_q && !mem_we_q))
      else $error("phase sequence wrong");

   a_sub_flags: assert property (@(posedge clk) disable iff (rst)
      (s_q.phase == PH_Q3 && s_q.op == OP_SUB) |=>
      (status_q[`ST_C] == ({1'b0, $past(s_q.operand)} >=
      9'({1'b0, $past(s_q.w)} + {8'h00, ~$past(s_q.status[`ST_C])})) &&
      status_q[`ST_Z] == ($past(alu_bus.result) == 8'h00) &&
      status_q[`ST_N] == $past(alu_bus.result[7])))
      else $error("subtract flags wrong");

   c_sub_to_file: cover property (@(posedge clk) disable iff (rst)
      s_q.phase == PH_Q4 && s_q.op == OP_SUB && mem_we_q);
   c_swap_to_w: cover property (@(posedge clk) disable iff (rst)
      s_q.phase == PH_Q4 && s_q.op == OP_SWAP && !mem_we_q && done_q);
   c_indexed: cover property (@(posedge clk) disable iff (rst)
      taken && !instr[`BANK_BIT] && ext_set_en && file_f <= `ACCESS_LIMIT);
   c_borrow: cover property (@(posedge clk) disable iff (rst)
      s_q.phase == PH_Q4 && s_q.op == OP_SUB && !status_q[`ST_C]);
endmodule

// *** verification/tb_borrow_subtract_nibble_swap_exec.sv ***
// Purpose: Self-checking bench for the borrow subtract and nibble swap datapath.
// Assumes: Inputs change 1 ns after the rising edge; memory read data is held by the bench.
// Notes:   Read data is inverted after the read phase so stale data never matches.
`include "exec_params.svh"
module tb_borrow_subtract_nibble_swap_exec;
   timeunit 1ns;
   timeprecision 1ps;
   import exec_pkg::*;
   logic clk, rst, instr_valid, ext_set_en, preset_valid, mem_re_q, mem_we_q, done_q;
   logic [15:0] instr;
   logic [3:0] bank_select_reg;
   addr_t index_base, mem_addr_q;
   byte_t mem_rdata, preset_w, mem_wdata_q, w_q, cur_w;
   status_t preset_status, status_q, cur_st;
   phase_e phase_q;
   int num_errors, total_checks;

   borrow_subtract_nibble_swap_exec u_dut (.clk(clk), .rst(rst), .instr_valid(instr_valid),
      .instr(instr), .phase_q(phase_q), .done_q(done_q), .bank_select_reg(bank_select_reg),
      .ext_set_en(ext_set_en), .index_base(index_base), .mem_addr_q(mem_addr_q),
      .mem_re_q(mem_re_q), .mem_rdata(mem_rdata), .mem_we_q(mem_we_q),
      .mem_wdata_q(mem_wdata_q), .preset_valid(preset_valid), .preset_w(preset_w),
      .preset_status(preset_status), .w_q(w_q), .status_q(status_q));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic wait_q1;
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (phase_q !== PH_Q1 && n < 8);
      chk(phase_q, PH_Q1);
   endtask

   task automatic preset(input byte_t w, input status_t st);
      wait_q1();
      preset_valid = 1'b1;
      preset_w = w;
      preset_status = st;
      @(posedge clk);
      #1;
      preset_valid = 1'b0;
      cur_w = w;
      cur_st = st;
      chk(w_q, w);
      chk(status_q, st);
   endtask

   task automatic run_op(input logic [5:0] opc, input logic d, input logic a, input byte_t f,
                         input byte_t rd, input addr_t exp_addr);
      logic [8:0] full;
      logic [4:0] low;
      byte_t res;
      if (opc == `OPC_SUB_BORROW)
      begin
         full = {1'b0, rd} - {1'b0, cur_w} - {8'h00, ~cur_st[`ST_C]};
         low = {1'b0, rd[3:0]} - {1'b0, cur_w[3:0]} - {4'h0, ~cur_st[`ST_C]};
         res = full[7:0];
         cur_st = {res[7], (rd[7] ^ cur_w[7]) & (res[7] ^ rd[7]), res == 8'h00,
                   ~low[4], ~full[8]};
      end
      else
         res = {rd[3:0], rd[7:4]};
      wait_q1();
      instr = {opc, d, a, f};
      instr_valid = 1'b1;
      mem_rdata = rd;
      @(posedge clk);
      #1;
      instr_valid = 1'b0;
      chk(mem_addr_q, exp_addr);
      chk(mem_re_q, 1'b1);
      @(posedge clk);
      #1;
      mem_rdata = ~rd;
      chk({mem_re_q, done_q}, 2'b00);
      @(posedge clk);
      #1;
      chk(done_q, 1'b1);
      chk(mem_we_q, d);
      if (d)
         chk(mem_wdata_q, res);
      else
         cur_w = res;
      chk(w_q, cur_w);
      chk(status_q, cur_st);
   endtask

   task automatic sub_cases;
      preset(8'h0d, 5'h01);
      run_op(`OPC_SUB_BORROW, 1'b1, 1'b0, 8'h20, 8'h19, 12'h020);
      preset(8'h1a, 5'h00);
      bank_select_reg = 4'h3;
      run_op(`OPC_SUB_BORROW, 1'b0, 1'b1, 8'h44, 8'h1b, 12'h344);
      chk(w_q, 8'h00);
      preset(8'h0e, 5'h01);
      run_op(`OPC_SUB_BORROW, 1'b1, 1'b0, 8'h60, 8'h03, 12'hf60);
      run_op(`OPC_SUB_BORROW, 1'b0, 1'b0, 8'h5f, 8'h80, 12'h05f);
   endtask

   task automatic swap_cases;
      preset(8'h3c, 5'h1f);
      ext_set_en = 1'b1;
      index_base = 12'hfe0;
      run_op(`OPC_NIBBLE_SWAP, 1'b1, 1'b0, 8'h5f, 8'ha5, 12'h03f);
      run_op(`OPC_NIBBLE_SWAP, 1'b0, 1'b0, 8'h60, 8'h71, 12'hf60);
      run_op(`OPC_NIBBLE_SWAP, 1'b0, 1'b1, 8'hff, 8'h0f, 12'h3ff);
      ext_set_en = 1'b0;
   endtask

   task automatic refuse_case;
      wait_q1();
      instr = {6'h3f, 2'b11, 8'h10};
      instr_valid = 1'b1;
      repeat (3)
      begin
         @(posedge clk);
         #1;
         instr = {`OPC_SUB_BORROW, 2'b01, 8'h10};
         chk({mem_re_q, done_q, mem_we_q}, 3'b000);
      end
      instr_valid = 1'b0;
      @(posedge clk);
      #1;
      chk({mem_re_q, done_q, mem_we_q}, 3'b000);
      chk(w_q, cur_w);
   endtask

   initial
   begin
      rst = 1'b1;
      {instr_valid, ext_set_en, preset_valid} = 3'b000;
      instr = 16'h0000;
      bank_select_reg = 4'h0;
      index_base = 12'h000;
      mem_rdata = 8'h00;
      preset_w = 8'h00;
      preset_status = 5'h00;
      num_errors = 0;
      total_checks = 0;
      repeat (8) @(posedge clk);
      #1;
      rst = 1'b0;
      chk({w_q, 3'b000, status_q}, 16'h0000);
      chk({mem_re_q, mem_we_q, done_q, 1'b0, mem_addr_q}, 16'h0000);
      sub_cases();
      swap_cases();
      refuse_case();
      finish_test();
   end

   initial
   begin
      #(40 * 2000);
      num_errors++;
      finish_test();
   end
endmodule
